// ==== src/rrc_defines.svh ====
// Constants for the rotate-right-through-carry datapath
`ifndef RRC_DEFINES_SVH
`define RRC_DEFINES_SVH

`define RRC_OPCODE      6'h0C
`define RRC_OP_MSB      11
`define RRC_OP_LSB      6
`define RRC_DEST_BIT    5
`define RRC_ADDR_MSB    4
`define RRC_ADDR_LSB    0
`define RRC_DATA_MSB    7
`define RRC_DATA_LSB    0
`define RRC_ROT_LSB     1
`define RRC_FILE_DEPTH  32
`define RRC_W_RST       8'h00
`define RRC_C_RST       1'b0
`define RRC_Z_RST       1'b0
`define RRC_DC_RST      1'b0
`define RRC_DEST_W      1'b0
`define RRC_DEST_F      1'b1

`endif

// ==== src/rrc_pkg.sv ====
// Types for the rotate-right-through-carry datapath
package rrc_pkg;
    typedef logic [7:0]  byte_t;
    typedef logic [4:0]  faddr_t;
    typedef logic [11:0] insn_t;
    typedef enum logic {st_idle, st_exec} phase_e;
endpackage

// ==== src/rrc_file_mem.sv ====
// 32 x 8 file register memory with registered read data
`timescale 1ns/1ns
`include "rrc_defines.svh"
module rrc_file_mem
    import rrc_pkg::*;
(
    input  wire logic   sys_clk, // Clock
    input  wire logic   ce,      // Clock enable
    input  wire faddr_t raddr,   // Read address
    output byte_t       rdata,   // Registered read data
    input  wire logic   we,      // Write enable
    input  wire faddr_t waddr,   // Write address
    input  wire byte_t  wdata    // Write data
);
    byte_t mem [0:`RRC_FILE_DEPTH-1];

    always_ff @(posedge sys_clk) begin
        if (ce) begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end
endmodule // rrc_file_mem

// ==== src/rotate_right_carry.sv ====
// Rotate-right-through-carry instruction datapath
`timescale 1ns/1ns
`include "rrc_defines.svh"

// Function
// RL1: Match upper six opcode bits; bit 5 selects destination; bits 4:0 address.
// RL2: Shift right once; old carry enters bit 7; bit 0 becomes carry.
// RL3: Destination 0 writes accumulator; file register stays unchanged.
// RL4: Destination 1 writes file register; accumulator stays unchanged.
// RL5: One word, one instruction cycle; only carry changes among status bits.
module rotate_right_carry (
    input  wire logic           sys_clk,    // 100 MHz clock
    input  wire logic           rst,        // Sync reset, active high
    input  wire logic           ce,         // Clock enable
    input  wire rrc_pkg::insn_t insn,       // Instruction word
    input  wire logic           insn_valid, // Instruction presented
    input  wire logic           ld_we,      // Preload file write
    input  wire rrc_pkg::faddr_t ld_addr,   // Preload address
    input  wire rrc_pkg::byte_t ld_data,    // Preload data
    output rrc_pkg::byte_t      w_out,      // Working accumulator
    output logic                c_out,      // Carry flag
    output logic                z_out,      // Zero flag
    output logic                dc_out,     // Digit-carry flag
    output logic                done,       // Instruction retired pulse
    output rrc_pkg::byte_t      f_out,      // Last exec file write data
    output rrc_pkg::faddr_t     f_addr_out  // Last exec file write address
);
    import rrc_pkg::*;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    function automatic logic is_rrc(input insn_t i);
        is_rrc = (i[`RRC_OP_MSB:`RRC_OP_LSB] == `RRC_OPCODE);
    endfunction

    wire logic   hit  = insn_valid & is_rrc(insn);         // see RL1
    wire logic   dest = insn[`RRC_DEST_BIT];               // see RL1
    wire faddr_t addr = insn[`RRC_ADDR_MSB:`RRC_ADDR_LSB]; // see RL1

    // ----------------------------------------
    // State
    // ----------------------------------------
    phase_e ph_r;
    phase_e ph_nxt;
    logic   dest_r;
    faddr_t addr_r;
    byte_t  w_r;
    logic   c_r;
    logic   z_r;
    logic   dc_r;
    logic   done_r;
    byte_t  fo_r;
    faddr_t fa_r;
    byte_t  op;

    // Fetch phase reads the operand, exec phase retires: one cycle per insn
    always_comb begin
        case (ph_r)
            st_idle: ph_nxt = hit ? st_exec : st_idle;
            st_exec: ph_nxt = hit ? st_exec : st_idle;
            default: ph_nxt = st_idle;
        endcase
    end

    // ----------------------------------------
    // Datapath
    // ----------------------------------------
    // One-bit rotate with the carry flag as the ninth bit
    function automatic byte_t rot_right(input byte_t v, input logic cin);
        rot_right = {cin, v[`RRC_DATA_MSB:`RRC_ROT_LSB]};
    endfunction

    function automatic logic rot_carry(input byte_t v);
        rot_carry = v[`RRC_DATA_LSB];
    endfunction

    wire logic  exec   = (ph_r == st_exec);
    wire byte_t rot    = rot_right(op, c_r);                // see RL2
    wire logic  c_new  = rot_carry(op);                     // see RL2
    // Destination bit steers the single write of this cycle
    wire logic  wr_w   = exec & (dest_r == `RRC_DEST_W);    // see RL3
    wire logic  wr_f   = exec & (dest_r == `RRC_DEST_F);    // see RL4
    // ----------------------------------------
    // Write arbitration
    // ----------------------------------------
    // The exec cycle owns the port; a preload in that cycle is dropped whatever the destination
    wire logic  mem_we = wr_f | (ld_we & ~exec);
    wire faddr_t mem_wa = wr_f ? addr_r : ld_addr;
    wire byte_t mem_wd = wr_f ? rot : ld_data;

    // ----------------------------------------
    // Next values
    // ----------------------------------------
    wire byte_t  w_nxt  = wr_w ? rot : w_r;                 // see RL3
    wire logic   c_nxt  = exec ? c_new : c_r;               // see RL5
    wire byte_t  fo_nxt = wr_f ? rot : fo_r;                // see RL4
    wire faddr_t fa_nxt = wr_f ? addr_r : fa_r;             // see RL4

    // ----------------------------------------
    // Operand memory
    // ----------------------------------------
    // Read data is registered, so the operand arrives in the exec cycle
    rrc_file_mem u_mem (
        .sys_clk (sys_clk),
        .ce      (ce),
        .raddr   (addr),
        .rdata   (op),
        .we      (mem_we),
        .waddr   (mem_wa),
        .wdata   (mem_wd)
    );

    // ----------------------------------------
    // Instruction capture
    // ----------------------------------------
    // Phase follows the decoded hit on every enabled edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ph_r <= st_idle;
        end else if (ce) begin
            ph_r <= ph_nxt;
        end
    end

    // Destination and address ride along into the exec cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dest_r <= `RRC_DEST_W;
        end else if (ce) begin
            dest_r <= dest;                                 // see RL1
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            addr_r <= '0;
        end else if (ce) begin
            addr_r <= addr;                                 // see RL1
        end
    end

    // ----------------------------------------
    // Results
    // ----------------------------------------
    // Accumulator and carry take the rotate only in the exec cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            w_r <= `RRC_W_RST;
        end else if (ce) begin
            w_r <= w_nxt;                                   // see RL3
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            c_r <= `RRC_C_RST;
        end else if (ce) begin
            c_r <= c_nxt;                                   // see RL2
        end
    end

    // Retire pulse marks the end of the exec cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            done_r <= 1'b0;
        end else if (ce) begin
            done_r <= exec;                                 // see RL5
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    // Zero and digit-carry are held: this op never touches them
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            z_r <= `RRC_Z_RST;
        end else if (ce) begin
            z_r <= z_r;                                     // see RL5
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dc_r <= `RRC_DC_RST;
        end else if (ce) begin
            dc_r <= dc_r;                                   // see RL5
        end
    end

    // ----------------------------------------
    // File write report
    // ----------------------------------------
    // Last exec file write, for the outside to observe; preload writes are not reported
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fo_r <= '0;
        end else if (ce) begin
            fo_r <= fo_nxt;                                 // see RL4
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fa_r <= '0;
        end else if (ce) begin
            fa_r <= fa_nxt;                                 // see RL4
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Every output is a flop
    assign w_out      = w_r;
    assign c_out      = c_r;
    assign z_out      = z_r;
    assign dc_out     = dc_r;
    assign done       = done_r;
    assign f_out      = fo_r;
    assign f_addr_out = fa_r;
endmodule // rotate_right_carry

// ==== dv/rotate_right_carry_props.sv ====
// Port assertions for the rotate datapath
`timescale 1ns/1ns
module rotate_right_carry_props
    import rrc_pkg::*;
(
    input wire logic   sys_clk, rst, ce, insn_valid, ld_we, // Inputs
    input wire logic   c_out, z_out, dc_out, done,          // Flags
    input wire insn_t  insn,                                // Insn word
    input wire faddr_t ld_addr, f_addr_out,                 // Addresses
    input wire byte_t  ld_data, w_out, f_out                // Data
);
    wire take = ce && insn_valid && insn[11:6] == 6'h0C;
    logic   t1_r, t2_r, d1_r, to_f, c_old;
    faddr_t a1_r, a_exp;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Track a taken insn through the enabled edges up to its retire
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            t1_r <= 1'b0;
            t2_r <= 1'b0;
        end else if (ce) begin
            t1_r <= take;
            t2_r <= t1_r;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (ce) begin
            d1_r  <= insn[5];
            to_f  <= d1_r;
            a1_r  <= insn[4:0];
            a_exp <= a1_r;
            c_old <= c_out;
        end
    end
    retire_on_time_a: assert property (take ##1 ce |=> done)
        else $error("no retire after insn");
    retire_cause_a: assert property (done |-> t2_r)
        else $error("retire without insn");
    w_dest_a: assert property (done && !to_f |-> w_out[7] == c_old
        && $stable(f_out) && $stable(f_addr_out))
        else $error("accumulator result wrong");
    f_dest_a: assert property (done && to_f |-> $stable(w_out)
        && f_addr_out == a_exp
        && f_out[7] == c_old)
        else $error("file result wrong");
    flags_kept_a: assert property (!z_out && !dc_out)
        else $error("zero or digit carry moved");
    idle_hold_a: assert property (!done && !$past(rst)
        |-> $stable(w_out) && $stable(c_out))
        else $error("state moved while idle");
    cover property (take && insn[5]);
    cover property (take && !insn[5]);
    cover property (done ##1 !done);
    cover property (take ##1 !ce);
endmodule // rotate_right_carry_props

bind rotate_right_carry rotate_right_carry_props rotate_right_carry_props_i (.*);

// ==== dv/tb.sv ====
// Self-checking bench for the rotate datapath
`timescale 1ns/1ns
module tb;
    import rrc_pkg::*;
    logic   sys_clk = 0, rst = 1, ce = 1, insn_valid = 0, ld_we = 0;
    logic   c_out, z_out, dc_out, done;
    insn_t  insn = 12'h000;
    faddr_t ld_addr = 5'h00, f_addr_out;
    byte_t  ld_data = 8'h00, w_out, f_out;
    int     fails = 0, n_checks = 0, cyc = 0;
    // Preload, dest, addr, data, expected {carry, result}
    logic [23:0] rows [6] = '{{1'b1, 1'b0, 5'h00, 8'hE6, 9'h073},
        {1'b1, 1'b1, 5'h1F, 8'h01, 9'h100}, {1'b1, 1'b0, 5'h05, 8'h80, 9'h0C0},
        {1'b1, 1'b1, 5'h07, 8'hFF, 9'h17F}, {1'b0, 1'b0, 5'h1F, 8'h00, 9'h080},
        {1'b0, 1'b0, 5'h00, 8'h00, 9'h073}};

    rotate_right_carry rotate_right_carry_i (.*);

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 500) begin
            fails++;
            give_verdict();
        end
    end

    task automatic check(logic [8:0] seen, logic [8:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (fails == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic issue(logic [5:0] op, logic [23:0] r);
        int k;
        @(posedge sys_clk);
        ld_we <= r[23];
        ld_addr <= r[21:17];
        ld_data <= r[16:9];
        @(posedge sys_clk);
        ld_we <= 1'b0;
        insn <= {op, r[22:17]};
        insn_valid <= 1'b1;
        @(posedge sys_clk);
        insn_valid <= 1'b0;
        for (k = 0; k < 5 && done !== 1'b1; k++) begin
            @(posedge sys_clk);
            #1;
        end
    endtask

    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        #1;
        check({c_out, w_out}, 9'h000);
        foreach (rows[i]) begin
            issue(6'h0C, rows[i]);
            check({6'h00, done, z_out, dc_out}, 9'h004);
            check({c_out, rows[i][22] ? f_out : w_out}, rows[i][8:0]);
            if (rows[i][22]) check({4'h0, f_addr_out}, {4'h0, rows[i][21:17]});
        end
        issue(6'h0D, 24'h000000);
        check({c_out, w_out}, 9'h073);
        check({8'h00, done}, 9'h000);
        // Clock enable low in the exec cycle holds the retire back
        @(posedge sys_clk);
        insn <= {6'h0C, 1'b0, 5'h05};
        insn_valid <= 1'b1;
        @(posedge sys_clk);
        insn_valid <= 1'b0;
        ce <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        check({done, w_out}, 9'h073);
        @(posedge sys_clk);
        ce <= 1'b1;
        @(posedge sys_clk);
        #1;
        check({done, w_out}, 9'h140);
        check({8'h00, c_out}, 9'h000);
        // Reset in mid-run clears the outputs, then work resumes
        @(posedge sys_clk);
        rst <= 1'b1;
        @(posedge sys_clk);
        #1;
        check({done, f_out}, 9'h000);
        check({c_out, w_out}, 9'h000);
        check({4'h0, f_addr_out}, 9'h000);
        @(posedge sys_clk);
        rst <= 1'b0;
        issue(6'h0C, {2'b00, 5'h05, 8'h00, 9'h000});
        check({done, w_out}, 9'h140);
        give_verdict();
    end
endmodule // tb
